// ===== nvmsc_pkg.sv
// Constants, types and register map of the memory scanner
//
// Overview of operation
// - Burst mode holds processor until scan ends
// - Burst go bit ends by hardware end or by a software control write
// - Mode 01 burst, start at once, stall throughout
// - Mode 00 stalls processor only per access
// - Mode 11 waits trigger rising edge first
// - Mode 10 uses only idle memory cycles
// - Priority 1 burst: interrupt pauses the burst
// - Priority 1 modes 00 and 11: suspend during interrupt
// - Priority 0 burst: interrupt deferred until done
// - Priority 0 other modes: keep accessing memory
// - End address writes ignored while go set
package nvmsc_pkg;
   localparam int NVMSC_ADDR_W = 16;
   localparam int NVMSC_DATA_W = 16;
   // Register byte offsets
   localparam logic [7:0] NVMSC_OFS_CTRL   = 8'h00;
   localparam logic [7:0] NVMSC_OFS_ENDH   = 8'h04;
   localparam logic [7:0] NVMSC_OFS_ENDL   = 8'h08;
   localparam logic [7:0] NVMSC_OFS_START  = 8'h0c;
   localparam logic [7:0] NVMSC_OFS_TRIG   = 8'h10;
   localparam logic [7:0] NVMSC_OFS_ISTAT  = 8'h14;
   localparam logic [7:0] NVMSC_OFS_IMASK  = 8'h18;
   // Control register fields
   localparam int NVMSC_B_EN    = 7;
   localparam int NVMSC_B_GO    = 6;
   localparam int NVMSC_B_BUSY  = 5;
   localparam int NVMSC_B_INVAL = 4;
   localparam int NVMSC_B_INTERRUPT_PRIORITY_SELECT  = 3;
   localparam int NVMSC_B_MODE  = 0;
   // Interrupt status fields
   localparam int NVMSC_B_DONE  = 0;
   localparam int NVMSC_B_BADAD = 1;
   localparam int NVMSC_IRQ_W   = 2;
   localparam logic [1:0] NVMSC_HTRANS_NONSEQ = 2'h2;
   localparam logic       NVMSC_HRESP_OKAY    = 1'h0;
   localparam logic [NVMSC_ADDR_W-1:0] NVMSC_ADDR_RST = 16'h0000;
   localparam logic [NVMSC_ADDR_W-1:0] NVMSC_ADDR_ONE = 16'h0001;

   typedef enum logic [1:0] {
      NVMSC_MODE_CONC  = 2'b00,
      NVMSC_MODE_BURST = 2'b01,
      NVMSC_MODE_PEEK  = 2'b10,
      NVMSC_MODE_TRIG  = 2'b11
   } nvmsc_mode_t;

   typedef enum logic [1:0] {
      NVMSC_ST_IDLE   = 2'b00,
      NVMSC_ST_ARM    = 2'b01,
      NVMSC_ST_WAIT   = 2'b10,
      NVMSC_ST_ACCESS = 2'b11
   } nvmsc_state_t;

   // AHB-Lite address phase
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
   } nvmsc_ahb_req_t;

   // Word handed to the client
   typedef struct packed {
      logic                    valid;
      logic [NVMSC_ADDR_W-1:0] addr;
      logic [NVMSC_DATA_W-1:0] data;
   } nvmsc_word_t;
endpackage

// ===== nvmsc_top.sv
// Memory scanner: AHB-Lite registers, scan engine, processor arbitration
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
module nvmsc_top #(
   parameter int TRIG_N    = 4,
   parameter int MEM_WORDS = 16384
) (
   // Clock and reset
   input  wire logic                              ref_clk,
   input  wire logic                              reset,
   // AHB-Lite slave
   input  wire nvmsc_pkg::nvmsc_ahb_req_t         ahbReq,
   input  wire logic                              hready,
   input  wire logic [31:0]                       hwdata,
   output logic [31:0]                            hrdata,
   output logic                                   hreadyout,
   output logic                                   hresp,
   // Processor side
   input  wire logic                              cpuNeedsMem,
   input  wire logic                              cpuIrqActive,
   output logic                                   cpuStall,
   output logic                                   irqDefer,
   // Program memory read port
   input  wire logic                              memValid,
   input  wire logic [nvmsc_pkg::NVMSC_DATA_W-1:0] memRdata,
   output logic                                   memReq,
   output logic [nvmsc_pkg::NVMSC_ADDR_W-1:0]     memAddr,
   // Client peripheral
   input  wire logic                              clientReady,
   output nvmsc_pkg::nvmsc_word_t                 clientWord,
   // Trigger sources, asynchronous
   input  wire logic [TRIG_N-1:0]                 trigIn,
   // Interrupt
   output logic                                   irq
);
   import nvmsc_pkg::*;

   // Trigger select is one byte wide, the scan pointer one word
   if (TRIG_N < 1 || TRIG_N > 256) begin : g_trig_chk
      $error("TRIG_N out of range");
   end
   if (MEM_WORDS < 1 || MEM_WORDS > 65536) begin : g_mem_chk
      $error("MEM_WORDS out of range");
   end

   localparam logic [16:0] MEM_LIMIT = 17'(MEM_WORDS);

   // Registers
   logic                    enReg;
   logic                    goReg;
   logic                    intmReg;
   nvmsc_mode_t             modeReg;
   logic [NVMSC_ADDR_W-1:0] endReg;
   logic [NVMSC_ADDR_W-1:0] startReg;
   logic [7:0]              trigSelReg;
   logic [NVMSC_IRQ_W-1:0]  istatReg;
   logic [NVMSC_IRQ_W-1:0]  imaskReg;
   nvmsc_state_t            stateReg;
   nvmsc_state_t            stateNext;
   logic [NVMSC_ADDR_W-1:0] addrReg;
   logic                    wrPendReg;
   logic [7:0]              wrAddrReg;
   logic [TRIG_N-1:0]       trigMeta;
   logic [TRIG_N-1:0]       trigSync;
   logic [TRIG_N-1:0]       trigLast;

   // Bus decode
   wire addrPhase = ahbReq.hsel && ahbReq.htrans == NVMSC_HTRANS_NONSEQ && hready;
   wire [7:0] rdOfs = ahbReq.haddr[7:0];
   wire wrCtrl  = wrPendReg && wrAddrReg == NVMSC_OFS_CTRL;
   wire wrEndH  = wrPendReg && wrAddrReg == NVMSC_OFS_ENDH;
   wire wrEndL  = wrPendReg && wrAddrReg == NVMSC_OFS_ENDL;
   wire wrStart = wrPendReg && wrAddrReg == NVMSC_OFS_START;
   wire wrTrig  = wrPendReg && wrAddrReg == NVMSC_OFS_TRIG;
   wire wrIstat = wrPendReg && wrAddrReg == NVMSC_OFS_ISTAT;
   wire wrImask = wrPendReg && wrAddrReg == NVMSC_OFS_IMASK;

   // Scan conditions
   // invalid flag follows pointer
   wire addrInvalid = {1'b0, addrReg} >= MEM_LIMIT;
   wire isBurst     = modeReg == NVMSC_MODE_BURST;
   wire isPeek      = modeReg == NVMSC_MODE_PEEK;
   wire trigPick    = trigSync[trigSelReg % TRIG_N];
   wire trigPickOld = trigLast[trigSelReg % TRIG_N];
   wire trigRise    = trigPick && !trigPickOld;
   wire pauseScan   = intmReg && cpuIrqActive && !isPeek;
   // peek waits for a free memory cycle
   wire slotFree    = !isPeek || !cpuNeedsMem;
   // access only when client is ready
   wire canStart    = goReg && clientReady && !pauseScan && slotFree && !addrInvalid;
   wire accessDone  = stateReg == NVMSC_ST_ACCESS && memValid;
   wire lastWord    = addrReg >= endReg;
   // end past end address or invalid address
   wire scanEnd     = enReg && ((accessDone && lastWord)
                      || (stateReg == NVMSC_ST_WAIT && goReg && addrInvalid));
   wire goWrite     = wrCtrl && hwdata[NVMSC_B_GO];
   wire goRise      = goWrite && !goReg;
   // hardware end clears go, otherwise a control write loads it
   wire goNext      = scanEnd ? 1'b0 : (wrCtrl ? hwdata[NVMSC_B_GO] : goReg);
   wire [NVMSC_IRQ_W-1:0] evtSet = {scanEnd && addrInvalid, scanEnd};
   wire [NVMSC_IRQ_W-1:0] istatClr = wrIstat ? hwdata[NVMSC_IRQ_W-1:0] : '0;
   // Values a control write is loading, so a stale mode never stalls
   wire enNext      = wrCtrl ? hwdata[NVMSC_B_EN] : enReg;
   wire intmNext    = wrCtrl ? hwdata[NVMSC_B_INTERRUPT_PRIORITY_SELECT] : intmReg;
   wire burstNext   = wrCtrl ? (hwdata[NVMSC_B_MODE +: 2] == NVMSC_MODE_BURST) : isBurst;
   // burst holds processor for the whole scan, except while a priority 1 interrupt is active
   wire burstHold   = enNext && goNext && burstNext && !(intmNext && cpuIrqActive);
   // processor stalled during a non-peek access and throughout a burst hold
   wire stallNext   = (stateNext == NVMSC_ST_ACCESS && !isPeek) || burstHold;
   wire deferNext   = enNext && goNext && burstNext && !intmNext;

   wire [7:0] ctrlRead = {enReg, goReg, stateReg == NVMSC_ST_ACCESS, addrInvalid,
                          intmReg, 1'b0, modeReg};
   wire [31:0] rdMux =
      rdOfs == NVMSC_OFS_CTRL  ? {24'h000000, ctrlRead} :
      rdOfs == NVMSC_OFS_ENDH  ? {24'h000000, endReg[15:8]} :
      rdOfs == NVMSC_OFS_ENDL  ? {24'h000000, endReg[7:0]} :
      rdOfs == NVMSC_OFS_START ? {16'h0000, startReg} :
      rdOfs == NVMSC_OFS_TRIG  ? {24'h000000, trigSelReg} :
      rdOfs == NVMSC_OFS_ISTAT ? {30'h00000000, istatReg} :
      rdOfs == NVMSC_OFS_IMASK ? {30'h00000000, imaskReg} : 32'h00000000;

   // Scan engine next state
   always_comb begin
      stateNext = stateReg;
      case (stateReg)
         NVMSC_ST_IDLE: begin
            if (goReg) begin
               stateNext = (modeReg == NVMSC_MODE_TRIG) ? NVMSC_ST_ARM : NVMSC_ST_WAIT;
            end
         end
         // first access only after trigger edge
         NVMSC_ST_ARM: begin
            if (!goReg) begin
               stateNext = NVMSC_ST_IDLE;
            end else if (trigRise) begin
               stateNext = NVMSC_ST_WAIT;
            end
         end
         NVMSC_ST_WAIT: begin
            if (!goReg || scanEnd) begin
               stateNext = NVMSC_ST_IDLE;
            end else if (canStart) begin
               stateNext = NVMSC_ST_ACCESS;
            end
         end
         // Access completes on memValid, unless enable low aborts it to idle
         NVMSC_ST_ACCESS: begin
            if (memValid) begin
               stateNext = (lastWord || !goReg) ? NVMSC_ST_IDLE : NVMSC_ST_WAIT;
            end
         end
         default: begin
            stateNext = NVMSC_ST_IDLE;
         end
      endcase
      // enable low resets the engine only
      if (!enReg) begin
         stateNext = NVMSC_ST_IDLE;
      end
   end

   // Trigger synchronisers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         trigMeta <= '0;
         trigSync <= '0;
         trigLast <= '0;
      end else begin
         trigMeta <= trigIn;
         trigSync <= trigMeta;
         trigLast <= trigSync;
      end
   end

   // Bus slave
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wrPendReg <= 1'b0;
         wrAddrReg <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b0;
         hresp     <= NVMSC_HRESP_OKAY;
      end else begin
         wrPendReg <= addrPhase && ahbReq.hwrite;
         wrAddrReg <= ahbReq.haddr[7:0];
         hrdata    <= (addrPhase && !ahbReq.hwrite) ? rdMux : 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= NVMSC_HRESP_OKAY;
      end
   end

   // Configuration registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         enReg      <= 1'b0;
         intmReg    <= 1'b0;
         modeReg    <= NVMSC_MODE_CONC;
         endReg     <= NVMSC_ADDR_RST;
         startReg   <= NVMSC_ADDR_RST;
         trigSelReg <= 8'h00;
         imaskReg   <= '0;
      end else begin
         if (wrCtrl) begin
            enReg   <= hwdata[NVMSC_B_EN];
            intmReg <= hwdata[NVMSC_B_INTERRUPT_PRIORITY_SELECT];
            modeReg <= nvmsc_mode_t'(hwdata[NVMSC_B_MODE +: 2]);
         end
         // end address frozen while go is set
         if (wrEndH && !goReg) begin
            endReg[15:8] <= hwdata[7:0];
         end
         if (wrEndL && !goReg) begin
            endReg[7:0] <= hwdata[7:0];
         end
         if (wrStart && !goReg) begin
            startReg <= hwdata[15:0];
         end
         if (wrTrig) begin
            trigSelReg <= hwdata[7:0];
         end
         if (wrImask) begin
            imaskReg <= hwdata[NVMSC_IRQ_W-1:0];
         end
      end
   end

   // Scan engine registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         goReg      <= 1'b0;
         stateReg   <= NVMSC_ST_IDLE;
         addrReg    <= NVMSC_ADDR_RST;
         istatReg   <= '0;
         irq        <= 1'b0;
         cpuStall   <= 1'b0;
         irqDefer   <= 1'b0;
         memReq     <= 1'b0;
         memAddr    <= NVMSC_ADDR_RST;
         clientWord <= '0;
      end else begin
         goReg    <= goNext;
         stateReg <= stateNext;
         if (goRise) begin
            addrReg <= startReg;
         end else if (accessDone) begin
            addrReg <= addrReg + NVMSC_ADDR_ONE;
         end
         // Event set wins over write-one clear
         istatReg <= (istatReg & ~istatClr) | evtSet;
         irq      <= |(istatReg & imaskReg);
         cpuStall <= stallNext;
         irqDefer <= deferNext;
         memReq   <= stateNext == NVMSC_ST_ACCESS;
         memAddr  <= (stateNext == NVMSC_ST_ACCESS) ? addrReg : memAddr;
         clientWord.valid <= accessDone;
         if (accessDone) begin
            clientWord.addr <= addrReg;
            clientWord.data <= memRdata;
         end
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_burst_hold: assert property (
      enReg && goReg && isBurst && !intmReg && !scanEnd |=> cpuStall)
      else $error("burst scan did not hold processor");

   a_burst_go_end: assert property (
      $fell(goReg) && $past(isBurst) && $past(enReg) |-> $past(scanEnd) || $past(wrCtrl))
      else $error("go fell without end condition");

   a_conc_stall: assert property (
      memReq && !isPeek |-> cpuStall)
      else $error("access without processor stall");

   a_trig_wait: assert property (
      stateReg == NVMSC_ST_ARM && !trigRise |=> !memReq)
      else $error("triggered scan started without edge");

   a_peek_free: assert property (
      isPeek && $past(isPeek) && !isBurst |-> !cpuStall)
      else $error("peek mode stalled processor");

   a_irq_pause: assert property (
      stateReg != NVMSC_ST_ACCESS && pauseScan |=> !memReq)
      else $error("scan continued during interrupt");

   a_burst_irq_off: assert property (
      intmReg && cpuIrqActive && isBurst && stateReg != NVMSC_ST_ACCESS |=> !cpuStall)
      else $error("burst not paused for interrupt");

   a_defer_irq: assert property (
      enReg && goReg && isBurst && !intmReg && !scanEnd |=> irqDefer)
      else $error("interrupt not deferred in burst");

   a_end_locked: assert property (
      goReg && (wrEndH || wrEndL) |=> $stable(endReg))
      else $error("end address changed while go set");

   a_go_clear: assert property (
      scanEnd |=> !goReg ##1 stateReg == NVMSC_ST_IDLE)
      else $error("go not cleared at scan end");

   a_word_out: assert property (
      $rose(memReq) |-> ##[1:200] (clientWord.valid || !enReg))
      else $error("access did not forward a word");

   a_irq_level: assert property (
      |(istatReg & imaskReg) |=> irq)
      else $error("interrupt output not raised");

   a_irq_clear: assert property (
      !(|(istatReg & imaskReg)) |=> !irq)
      else $error("interrupt output not lowered");

   a_burst_stall_end: assert property (
      scanEnd && isBurst |=> !cpuStall)
      else $error("burst stall held after scan end");

   a_peek_slot: assert property (
      $rose(memReq) && $past(isPeek) |-> !$past(cpuNeedsMem))
      else $error("peek access in a busy memory cycle");

   a_client_ready: assert property (
      $rose(memReq) |-> $past(clientReady))
      else $error("access started without client ready");

   a_en_idle: assert property (
      !enReg |=> stateReg == NVMSC_ST_IDLE && !memReq)
      else $error("disabled scanner kept running");

   a_busy_flag: assert property (
      memReq |-> ctrlRead[NVMSC_B_BUSY])
      else $error("busy flag low during access");

   a_bad_addr_end: assert property (
      stateReg == NVMSC_ST_WAIT && enReg && goReg && addrInvalid
      |=> !goReg && istatReg[NVMSC_B_BADAD])
      else $error("invalid pointer did not end scan");

   a_no_bad_read: assert property (
      memReq |-> {1'b0, memAddr} < MEM_LIMIT)
      else $error("read issued at invalid address");

endmodule // nvmsc_top

// ===== nvmsc_mem_model.sv
// Program memory model answering scan reads after a chosen delay
`timescale 1ns/100ps
module nvmsc_mem_model (
   // Clock and reset
   input  wire logic                                ref_clk,
   input  wire logic                                reset,
   // Answer delay in cycles, zero answers in the request cycle
   input  wire logic [3:0]                          delay,
   // Read port
   input  wire logic                                memReq,
   input  wire logic [nvmsc_pkg::NVMSC_ADDR_W-1:0]  memAddr,
   output logic                                     memValid,
   output logic [nvmsc_pkg::NVMSC_DATA_W-1:0]       memRdata
);
   import nvmsc_pkg::*;
   logic [3:0]              waitReg;
   logic [NVMSC_DATA_W-1:0] lastReg;
   assign memValid = memReq && (waitReg == delay);
   // Idle bus toggles, so a stale sample never looks right
   assign memRdata = memValid ? (memAddr ^ 16'h5a5a) : ~lastReg;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         waitReg <= 4'h0;
         lastReg <= 16'h0000;
      end else begin
         waitReg <= (memReq && !memValid) ? waitReg + 4'h1 : 4'h0;
         lastReg <= memRdata;
      end
   end
endmodule // nvmsc_mem_model

// ===== tb.sv
// Self-checking testbench of the memory scanner
`timescale 1ns/100ps
module tb;
   import nvmsc_pkg::*;
   typedef struct {
      nvmsc_mode_t mode;
      logic        interrupt_priority_select, irqAct;
      logic [15:0] first, last;
      logic [3:0]  lat;
      int          words;
      logic [1:0]  stat;
   } nvmsc_row_t;
   localparam int MEM_N = 32;
   logic           ref_clk, hready, hreadyout, hresp, memReq, memValid, irq, cpuStall, irqDefer;
   logic           reset = 1'b1, cpuNeedsMem = 1'b0, cpuIrqActive = 1'b0, clientReady = 1'b1;
   logic [31:0]    hwdata = 32'h0, hrdata, v;
   logic [15:0]    memRdata, memAddr, expAddr;
   logic [3:0]     trigIn = 4'h0, delay = 4'h0;
   logic [1:0]     phase = 2'h0;
   nvmsc_ahb_req_t ahbReq = '0;
   nvmsc_word_t    clientWord;
   nvmsc_row_t     r;
   int             nErrors, compares, nWords, nGap, nStall, nDefer;
   // Slow memory on the burst rows, invalid-end on the small memory
   nvmsc_row_t rows [6] = '{
      '{NVMSC_MODE_CONC,  1'b0, 1'b0, 16'h4,  16'h7,  4'h0, 4, 2'b01},
      '{NVMSC_MODE_BURST, 1'b0, 1'b1, 16'h4,  16'h7,  4'h2, 4, 2'b01},
      '{NVMSC_MODE_PEEK,  1'b1, 1'b0, 16'h8,  16'h9,  4'h0, 2, 2'b01},
      '{NVMSC_MODE_TRIG,  1'b0, 1'b0, 16'h2,  16'h3,  4'h1, 2, 2'b01},
      '{NVMSC_MODE_CONC,  1'b0, 1'b1, 16'h1e, 16'h28, 4'h1, 2, 2'b11},
      '{NVMSC_MODE_BURST, 1'b0, 1'b0, 16'h0,  16'h0,  4'h3, 1, 2'b01}
   };
   assign hready = hreadyout;
   nvmsc_top #(.TRIG_N(4), .MEM_WORDS(MEM_N)) dut (
      .ref_clk, .reset, .ahbReq, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
      .cpuNeedsMem, .cpuIrqActive, .cpuStall, .irqDefer, .memValid, .memRdata,
      .memReq, .memAddr, .clientReady, .clientWord, .trigIn, .irq
   );
   nvmsc_mem_model mem (.ref_clk, .reset, .delay, .memReq, .memAddr, .memValid, .memRdata);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Processor fetches three cycles of four, peek finds the fourth
   always @(posedge ref_clk) begin
      phase <= phase + 2'h1;
      cpuNeedsMem <= (phase != 2'h3);
   end
   always @(posedge ref_clk) begin
      if (clientWord.valid === 1'b1) begin
         checkBits("word addr", {16'h0, expAddr}, {16'h0, clientWord.addr});
         checkBits("word data", {16'h0, expAddr ^ 16'h5a5a}, {16'h0, clientWord.data});
         expAddr = expAddr + 16'h1;
         nWords++;
      end
      if (cpuStall === 1'b1) nStall++;
      if (cpuStall === 1'b1 && memReq !== 1'b1) nGap++;
      if (irqDefer === 1'b1) nDefer++;
   end
   task automatic checkBits(input string name, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         nErrors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic checkInt(input string name, input int exp, got);
      compares++;
      if (got != exp) begin
         nErrors++;
         $display("Error %s expected %0d seen %0d", name, exp, got);
      end
   endtask
   // Waits have no own limit, the watchdog ends a hang
   task automatic busCycle(input logic [7:0] a, input logic wr, input logic [31:0] d);
      @(posedge ref_clk);
      ahbReq <= '{1'b1, {24'h0, a}, NVMSC_HTRANS_NONSEQ, wr, 3'h2};
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      ahbReq <= '{1'b0, {24'h0, a}, 2'h0, wr, 3'h2};
      hwdata <= d;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      v = hrdata;
      checkBits("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic busWr(input logic [7:0] a, input logic [31:0] d);
      busCycle(a, 1'b1, d);
   endtask
   task automatic busRd(input logic [7:0] a);
      busCycle(a, 1'b0, 32'h0);
   endtask
   task automatic waitIdle();
      busRd(NVMSC_OFS_CTRL);
      for (int k = 0; k < 500 && v[NVMSC_B_GO] !== 1'b0; k++) busRd(NVMSC_OFS_CTRL);
      checkBits("go cleared", 32'h0, {31'h0, v[NVMSC_B_GO]});
   endtask
   task automatic startScan(input logic [15:0] first, input logic [31:0] ctrl);
      expAddr = first;
      nWords = 0;
      nGap = 0;
      nStall = 0;
      nDefer = 0;
      busWr(NVMSC_OFS_CTRL, ctrl);
   endtask
   task automatic stopTest();
      $display("compares %0d errors %0d", compares, nErrors);
      if (nErrors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      nErrors++;
      $display("Error watchdog expected end seen hang");
      stopTest();
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      foreach (rows[i]) begin
         r = rows[i];
         delay <= r.lat;
         cpuIrqActive <= r.irqAct;
         trigIn <= 4'h0;
         busWr(NVMSC_OFS_ENDH, {24'h0, r.last[15:8]});
         busWr(NVMSC_OFS_ENDL, {24'h0, r.last[7:0]});
         busWr(NVMSC_OFS_START, {16'h0, r.first});
         busWr(NVMSC_OFS_TRIG, 32'h1);
         startScan(r.first, {24'h0, 4'hc, r.interrupt_priority_select, 1'b0, r.mode});
         repeat (10) @(posedge ref_clk);
         if (r.mode == NVMSC_MODE_TRIG) checkInt("early words", 0, nWords);
         trigIn <= 4'hf;
         waitIdle();
         checkInt("words", r.words, nWords);
         checkInt("stall gaps", int'(r.mode == NVMSC_MODE_BURST), int'(nGap > 0));
         if (r.mode == NVMSC_MODE_PEEK) checkInt("peek stalls", 0, nStall);
         checkInt("defer", int'(r.mode == NVMSC_MODE_BURST && !r.interrupt_priority_select), int'(nDefer > 0));
         checkBits("stall after end", 32'h0, {31'h0, cpuStall});
         busRd(NVMSC_OFS_CTRL);
         checkBits("ctrl", {24'h0, 3'b100, r.stat[1], r.interrupt_priority_select, 1'b0, r.mode}, v);
         busRd(NVMSC_OFS_ISTAT);
         checkBits("status", {30'h0, r.stat}, v);
         checkBits("irq masked", 32'h0, {31'h0, irq});
         busWr(NVMSC_OFS_IMASK, 32'h3);
         repeat (2) @(posedge ref_clk);
         checkBits("irq", 32'h1, {31'h0, irq});
         busWr(NVMSC_OFS_ISTAT, 32'h3);
         repeat (2) @(posedge ref_clk);
         checkBits("irq cleared", 32'h0, {31'h0, irq});
         busWr(NVMSC_OFS_IMASK, 32'h0);
         $display("row %0d done", i);
      end
      delay <= 4'h0;
      busWr(NVMSC_OFS_ENDH, 32'h0);
      busWr(NVMSC_OFS_ENDL, 32'h3);
      busWr(NVMSC_OFS_START, 32'h0);
      clientReady <= 1'b0;
      startScan(16'h0, 32'hc8);
      busWr(NVMSC_OFS_ENDL, 32'h55);
      busRd(NVMSC_OFS_ENDL);
      checkBits("end low locked", 32'h3, v);
      checkInt("words client busy", 0, nWords);
      clientReady <= 1'b1;
      cpuIrqActive <= 1'b1;
      repeat (20) @(posedge ref_clk);
      checkInt("words in interrupt", 0, nWords);
      busWr(NVMSC_OFS_CTRL, 32'h48);
      cpuIrqActive <= 1'b0;
      repeat (10) @(posedge ref_clk);
      busRd(NVMSC_OFS_CTRL);
      checkBits("ctrl kept", 32'h48, v);
      checkInt("words disabled", 0, nWords);
      busWr(NVMSC_OFS_CTRL, 32'hc8);
      waitIdle();
      checkInt("words resumed", 4, nWords);
      $display("lock test done");
      cpuIrqActive <= 1'b1;
      startScan(16'h0, 32'hc9);
      repeat (10) @(posedge ref_clk);
      checkBits("burst stall in interrupt", 32'h0, {31'h0, cpuStall});
      checkInt("burst words in interrupt", 0, nWords);
      cpuIrqActive <= 1'b0;
      waitIdle();
      checkInt("burst words resumed", 4, nWords);
      $display("burst pause test done");
      busWr(8'h1c, 32'hffffffff);
      busRd(8'h1c);
      checkBits("unmapped", 32'h0, v);
      reset <= 1'b1;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      busRd(NVMSC_OFS_CTRL);
      checkBits("ctrl after reset", 32'h0, v);
      busRd(NVMSC_OFS_ENDL);
      checkBits("end low after reset", 32'h0, v);
      $display("reset test done");
      stopTest();
   end
endmodule // tb
